// ==== hdl/aep_flag.sv ====
// Sticky fault flag where a set beats a clear in the same cycle
module aep_flag
	import aep_pkg::*;
(
	// Clock and reset
	input  wire logic clk,
	input  wire logic srst,
	// Set, clear and state
	input  wire logic set,
	input  wire logic clr,
	output logic      q
);

	logic d;    // Next state

	// Set wins so an event in the clear cycle is kept
	always_comb begin
		d = q;
		if (clr)
			d = 1'b0;
		if (set)
			d = 1'b1;
	end

	// Register only
	always_ff @(posedge clk) begin
		if (srst)
			q <= 1'b0;
		else
			q <= d;
	end

	property p_sticky;
		@(posedge clk) disable iff (srst) q && !clr |=> q;
	endproperty
	a_sticky: assert property (p_sticky) else $error("fault flag dropped");

endmodule

// ==== hdl/aep_pkg.sv ====
// Constants, register map and types for the absolute encoder position tracker
//******************************************************************************
//******************************************************************************
package aep_pkg;

	//**************************************************************************
	// Widths
	//**************************************************************************
	localparam int TURN_W = 16;          // Multi-turn count from the encoder
	localparam int EXT_W  = 17;          // Turn count with room to overflow
	localparam int ANG_W  = 24;          // Widest single-turn angle
	localparam int POS_W  = 48;          // Signed encoder position
	localparam int DATA_W = 32;          // Register data
	localparam int ADDR_W = 8;           // Register byte address
	localparam int RES17  = 17;          // Shift for 17-bit angle
	localparam int RES24  = 24;          // Shift for 24-bit angle

	//**************************************************************************
	// Angle masks and half-turn thresholds
	//**************************************************************************
	localparam logic [ANG_W-1:0] MASK17 = 24'h01FFFF;
	localparam logic [ANG_W-1:0] MASK24 = 24'hFFFFFF;
	localparam logic [ANG_W-1:0] HALF17 = 24'h010000;
	localparam logic [ANG_W-1:0] HALF24 = 24'h800000;

	// Travel limits in turns, plus and minus 32767
	localparam logic [EXT_W-1:0] TURN_MAX = 17'h07FFF;
	localparam logic [EXT_W-1:0] TURN_MIN = 17'h18001;

	//**************************************************************************
	// Register byte addresses
	//**************************************************************************
	localparam logic [ADDR_W-1:0] A_CTRL    = 8'h00;  // Mode, resolution, home
	localparam logic [ADDR_W-1:0] A_STATUS  = 8'h04;  // Sticky faults, RO
	localparam logic [ADDR_W-1:0] A_CLEAR   = 8'h08;  // Write one to clear, WO
	localparam logic [ADDR_W-1:0] A_ENABLE  = 8'h0C;  // Interrupt enables
	localparam logic [ADDR_W-1:0] A_TURNS   = 8'h10;  // Extended turn count
	localparam logic [ADDR_W-1:0] A_ANGLE   = 8'h14;  // Single-turn angle
	localparam logic [ADDR_W-1:0] A_ENC_LO  = 8'h18;
	localparam logic [ADDR_W-1:0] A_ENC_HI  = 8'h1C;
	localparam logic [ADDR_W-1:0] A_OFS_LO  = 8'h20;  // Zero offset, RW
	localparam logic [ADDR_W-1:0] A_OFS_HI  = 8'h24;
	localparam logic [ADDR_W-1:0] A_MECH_LO = 8'h28;
	localparam logic [ADDR_W-1:0] A_MECH_HI = 8'h2C;
	localparam logic [ADDR_W-1:0] A_TARGET  = 8'h30;  // Segment target, RW
	localparam logic [ADDR_W-1:0] A_ERROR   = 8'h34;  // Target minus mech
	localparam logic [ADDR_W-1:0] A_STATE   = 8'h38;  // Home-needed, tracking

	// Control bits
	localparam int C_MODE = 0;
	localparam int C_RES  = 1;
	localparam int C_HOME = 2;

	// Status bits
	localparam int S_OVF   = 0;
	localparam int S_BFAIL = 1;
	localparam int S_BLOW  = 2;
	localparam int S_HOME  = 3;
	localparam int NUM_EV  = 4;

	//**************************************************************************
	// Types
	//**************************************************************************
	typedef enum logic {
		AEP_INCR = 1'b0,
		AEP_ABS  = 1'b1
	} aep_usage_e;

	typedef enum logic [1:0] {
		AEP_WAIT  = 2'b00,    // No sample since reset
		AEP_TRACK = 2'b01     // Following the encoder
	} aep_trk_e;

endpackage

// ==== hdl/aep_sync.sv ====
// Two-flop synchroniser for a group of pin inputs
module aep_sync
	import aep_pkg::*;
#(
	parameter int W = 1
) (
	// Clock and reset
	input  wire logic         clk,
	input  wire logic         srst,
	// Pins and synchronised copy
	input  wire logic [W-1:0] d,
	output logic      [W-1:0] q
);

	logic [W-1:0] meta_q;    // First stage, read only by the second

	// Two stages, both cleared by reset
	always_ff @(posedge clk) begin
		if (srst) begin
			meta_q <= '0;
			q      <= '0;
		end else begin
			meta_q <= d;
			q      <= meta_q;
		end
	end

endmodule

// ==== hdl/aep_tracker.sv ====
// Absolute encoder position tracker with register port and fault interrupt
module aep_tracker
	import aep_pkg::*;
(
	// Clock and reset
	input  wire logic                  clk,
	input  wire logic                  srst,
	// Encoder pins
	input  wire logic [TURN_W-1:0]     enc_turns,
	input  wire logic [ANG_W-1:0]      enc_angle,
	input  wire logic                  enc_stb,
	input  wire logic                  enc_batt_first,
	input  wire logic                  enc_batt_low,
	// Register port
	input  wire logic [ADDR_W-1:0]     addr,
	input  wire logic [DATA_W-1:0]     wdata,
	input  wire logic                  wr,
	input  wire logic                  rd,
	output logic      [DATA_W-1:0]     rdata,
	// Results
	output logic                       irq,
	output logic                       home_needed,
	output logic      [DATA_W-1:0]     mech_pos,
	output logic      [DATA_W-1:0]     pos_error
);

	//**************************************************************************
	// Pin synchronisers
	//**************************************************************************
	logic [TURN_W-1:0] s_turns;     // Synchronised turn count
	logic [ANG_W-1:0]  s_angle;     // Synchronised angle
	logic              s_stb;       // Synchronised sample strobe
	logic              s_bfirst;    // Battery first-connect flag
	logic              s_blow;      // Battery low flag

	// Encoder must hold the words stable around its strobe; one equal-latency chain
	aep_sync #(.W(TURN_W + ANG_W + 3)) u_sync (
		.clk  (clk),
		.srst (srst),
		.d    ({enc_turns, enc_angle, enc_stb, enc_batt_first, enc_batt_low}),
		.q    ({s_turns, s_angle, s_stb, s_bfirst, s_blow})
	);

	//**************************************************************************
	// Register write decode
	//**************************************************************************
	logic home_req;     // Homing command
	logic clr_wr;       // Write to clear register
	assign home_req = wr && (addr == A_CTRL) && wdata[C_HOME];
	assign clr_wr   = wr && (addr == A_CLEAR);

	//**************************************************************************
	// Configuration registers
	//**************************************************************************
	aep_usage_e        mode_q, mode_d;      // Usage mode select
	logic              res24_q, res24_d;    // 24-bit angle when set
	logic [NUM_EV-1:0] en_q, en_d;          // Interrupt enables
	logic [DATA_W-1:0] tgt_q, tgt_d;        // Segment target, user units

	// Software settings
	always_comb begin
		mode_d  = mode_q;
		res24_d = res24_q;
		en_d    = en_q;
		tgt_d   = tgt_q;
		if (wr && addr == A_CTRL) begin
			mode_d  = aep_usage_e'(wdata[C_MODE]);
			res24_d = wdata[C_RES];
		end
		if (wr && addr == A_ENABLE)
			en_d = wdata[NUM_EV-1:0];
		if (wr && addr == A_TARGET)
			tgt_d = wdata;
	end

	always_ff @(posedge clk) begin
		if (srst) begin
			mode_q  <= AEP_INCR;
			res24_q <= 1'b0;
			en_q    <= '0;
			tgt_q   <= '0;
		end else begin
			mode_q  <= mode_d;
			res24_q <= res24_d;
			en_q    <= en_d;
			tgt_q   <= tgt_d;
		end
	end

	//**************************************************************************
	// Turn tracking
	//**************************************************************************
	aep_trk_e          trk_q, trk_d;        // Tracking state
	logic [EXT_W-1:0]  turns_q, turns_d;    // Signed turn count
	logic [ANG_W-1:0]  ang_q, ang_d;        // Last angle
	logic              samp_q;              // Strobe delay for edge
	logic              samp;                // New sample this cycle
	logic [ANG_W-1:0]  mask, half, new_ang; // Resolution helpers

	assign samp    = s_stb && !samp_q;
	assign mask    = res24_q ? MASK24 : MASK17;
	assign half    = res24_q ? HALF24 : HALF17;
	assign new_ang = s_angle & mask;

	// Wrap detection counts turns; a jump over half a turn is a wrap
	always_comb begin
		trk_d   = trk_q;
		turns_d = turns_q;
		ang_d   = ang_q;
		if (samp) begin
			ang_d = new_ang;
			case (trk_q)
				AEP_WAIT: begin
					trk_d = AEP_TRACK;
					// Absolute resumes the retained count, incremental starts at 0
					if (mode_q == AEP_ABS)
						turns_d = {s_turns[TURN_W-1], s_turns};
					else
						turns_d = '0;
				end
				AEP_TRACK: begin
					if (ang_q > new_ang && (ang_q - new_ang) > half)
						turns_d = turns_q + 17'h00001;
					else if (new_ang > ang_q && (new_ang - ang_q) > half)
						turns_d = turns_q - 17'h00001;
				end
				default: trk_d = AEP_WAIT;
			endcase
		end
	end

	always_ff @(posedge clk) begin
		if (srst) begin
			trk_q   <= AEP_WAIT;
			turns_q <= '0;
			ang_q   <= '0;
			samp_q  <= 1'b0;
		end else begin
			trk_q   <= trk_d;
			turns_q <= turns_d;
			ang_q   <= ang_d;
			samp_q  <= s_stb;
		end
	end

	//**************************************************************************
	// Positions and homing
	//**************************************************************************
	logic signed [POS_W-1:0] turns_x, raw;          // Raw encoder position
	logic [POS_W-1:0] base_q, base_d;               // Incremental origin
	logic [POS_W-1:0] ofs_q, ofs_d;                 // Mechanical zero offset
	logic [POS_W-1:0] enc_q, enc_d;                 // Encoder position
	logic [POS_W-1:0] mech_q, mech_d;               // Mechanical position
	logic [DATA_W-1:0] err_q, err_d;                // Target error
	logic              hn_q, hn_d;                  // Homing still needed

	assign turns_x = {{(POS_W-EXT_W){turns_q[EXT_W-1]}}, turns_q};
	// Signed turns scaled by counts per turn plus angle
	assign raw = (res24_q ? (turns_x <<< RES24) : (turns_x <<< RES17))
	           + $signed({{(POS_W-ANG_W){1'b0}}, ang_q});

	// Pipeline is encoder, then mechanical, then error; one cycle each
	always_comb begin
		base_d = base_q;
		ofs_d  = ofs_q;
		hn_d   = hn_q;
		enc_d  = POS_W'(raw) - base_q;
		mech_d = enc_q - ofs_q;
		err_d  = tgt_q - mech_q[DATA_W-1:0];
		// Offset may be restored by software after power-up
		if (wr && addr == A_OFS_LO)
			ofs_d[DATA_W-1:0] = wdata;
		if (wr && addr == A_OFS_HI)
			ofs_d[POS_W-1:DATA_W] = wdata[POS_W-DATA_W-1:0];
		if (home_req) begin
			hn_d = 1'b0;
			if (mode_q == AEP_INCR) begin
				base_d = POS_W'(raw);
				ofs_d  = '0;
			end else begin
				ofs_d = enc_q;
			end
		end
	end

	always_ff @(posedge clk) begin
		if (srst) begin
			base_q <= '0;
			ofs_q  <= '0;
			enc_q  <= '0;
			mech_q <= '0;
			err_q  <= '0;
			hn_q   <= 1'b1;
		end else begin
			base_q <= base_d;
			ofs_q  <= ofs_d;
			enc_q  <= enc_d;
			mech_q <= mech_d;
			err_q  <= err_d;
			hn_q   <= hn_d;
		end
	end

	assign home_needed = hn_q;
	assign mech_pos    = mech_q[DATA_W-1:0];
	assign pos_error   = err_q;

	//**************************************************************************
	// Faults and interrupt
	//**************************************************************************
	logic [NUM_EV-1:0] ev, st_q;    // Events and sticky status
	logic              ovf;         // Count beyond travel limit
	logic              irq_q;       // Registered interrupt

	assign ovf = ($signed(turns_d) > $signed(TURN_MAX))
	          || ($signed(turns_d) < $signed(TURN_MIN));
	assign ev[S_OVF]   = samp && trk_q == AEP_TRACK
	                  && mode_q == AEP_ABS && ovf;
	assign ev[S_BFAIL] = samp && trk_q == AEP_WAIT
	                  && mode_q == AEP_ABS && s_bfirst;
	assign ev[S_BLOW]  = s_blow;
	assign ev[S_HOME]  = home_req;

	// One sticky flag per event
	genvar gi;
	generate
		for (gi = 0; gi < NUM_EV; gi++) begin : g_flag
			aep_flag u_flag (
				.clk  (clk),
				.srst (srst),
				.set  (ev[gi]),
				.clr  (clr_wr && wdata[gi]),
				.q    (st_q[gi])
			);
		end
	endgenerate

	always_ff @(posedge clk) begin
		if (srst)
			irq_q <= 1'b0;
		else
			irq_q <= |(st_q & en_q);
	end
	assign irq = irq_q;

	//**************************************************************************
	// Register read, data one cycle after the strobe
	//**************************************************************************
	logic [DATA_W-1:0] rd_d, rd_q;    // Read data

	always_comb begin
		rd_d = '0;
		if (rd) begin
			case (addr)
				A_CTRL:    rd_d = DATA_W'({res24_q, mode_q});
				A_STATUS:  rd_d = DATA_W'(st_q);
				A_ENABLE:  rd_d = DATA_W'(en_q);
				A_TURNS:   rd_d = DATA_W'($signed(turns_q));
				A_ANGLE:   rd_d = DATA_W'(ang_q);
				A_ENC_LO:  rd_d = enc_q[DATA_W-1:0];
				A_ENC_HI:  rd_d = DATA_W'($signed(enc_q[POS_W-1:DATA_W]));
				A_OFS_LO:  rd_d = ofs_q[DATA_W-1:0];
				A_OFS_HI:  rd_d = DATA_W'($signed(ofs_q[POS_W-1:DATA_W]));
				A_MECH_LO: rd_d = mech_q[DATA_W-1:0];
				A_MECH_HI: rd_d = DATA_W'($signed(mech_q[POS_W-1:DATA_W]));
				A_TARGET:  rd_d = tgt_q;
				A_ERROR:   rd_d = err_q;
				A_STATE:   rd_d = DATA_W'({trk_q == AEP_TRACK, hn_q});
				default:   rd_d = '0;    // Clear register and holes read 0
			endcase
		end
	end

	always_ff @(posedge clk) begin
		if (srst)
			rd_q <= '0;
		else
			rd_q <= rd_d;
	end
	assign rdata = rd_q;

	//**************************************************************************
	// Checks; a home write that also flips resolution rescales the position
	//**************************************************************************
	property p_home_incr;
		@(posedge clk) disable iff (srst)
		home_req && mode_q == AEP_INCR && !samp && wdata[C_RES] == res24_q |-> ##2 enc_q == '0;
	endproperty
	a_home_incr: assert property (p_home_incr)
		else $error("incremental homing did not zero position");
	property p_home_abs;
		@(posedge clk) disable iff (srst)
		home_req && mode_q == AEP_ABS && !samp && wdata[C_RES] == res24_q
		|-> ##2 enc_q == $past(enc_q);
	endproperty
	a_home_abs: assert property (p_home_abs)
		else $error("absolute homing moved encoder position");
	property p_ofs;
		@(posedge clk) disable iff (srst)
		home_req && mode_q == AEP_ABS |=> ofs_q == $past(enc_q);
	endproperty
	a_ofs: assert property (p_ofs) else $error("zero offset not captured");
	property p_mech;
		@(posedge clk) disable iff (srst)
		!$past(srst) |-> mech_q == $past(enc_q) - $past(ofs_q);
	endproperty
	a_mech: assert property (p_mech) else $error("mechanical position wrong");
	// Enable seen by the interrupt register is the one a cycle earlier
	property p_ovf;
		@(posedge clk) disable iff (srst)
		ev[S_OVF] |=> st_q[S_OVF] ##1 irq || !$past(en_q[S_OVF]);
	endproperty
	a_ovf: assert property (p_ovf) else $error("overflow fault missed");
	property p_bfail;
		@(posedge clk) disable iff (srst)
		samp && trk_q == AEP_WAIT && mode_q == AEP_ABS && s_bfirst |=> st_q[S_BFAIL];
	endproperty
	a_bfail: assert property (p_bfail) else $error("battery power fail not reported");
	property p_blow;
		@(posedge clk) disable iff (srst) s_blow |=> st_q[S_BLOW];
	endproperty
	a_blow: assert property (p_blow) else $error("battery low not reported");
	property p_first;
		@(posedge clk) disable iff (srst)
		samp && trk_q == AEP_WAIT && mode_q == AEP_ABS
		|=> turns_q == {$past(s_turns[TURN_W-1]), $past(s_turns)} && trk_q == AEP_TRACK;
	endproperty
	a_first: assert property (p_first) else $error("retained turn count not loaded");
	property p_res;
		@(posedge clk) disable iff (srst) samp && !res24_q |=> ang_q[ANG_W-1:RES17] == '0;
	endproperty
	a_res: assert property (p_res) else $error("17-bit angle has high bits");
	property p_hn;
		@(posedge clk) srst |=> hn_q ##1 hn_q || $past(home_req);
	endproperty
	a_hn: assert property (p_hn) else $error("homing not required after reset");

endmodule

// ==== verif/aep_enc_model.sv ====
// Behavioural multi-turn absolute encoder driving the tracker pins
module aep_enc_model
	import aep_pkg::*;
(
	// Clock
	input  wire logic              clk,
	// Encoder pins
	output logic      [TURN_W-1:0] enc_turns,
	output logic      [ANG_W-1:0]  enc_angle,
	output logic                   enc_stb,
	output logic                   enc_batt_first,
	output logic                   enc_batt_low
);
	timeunit 1ns;
	timeprecision 1ps;

	//****************************************
	// Pins idle at time zero
	//****************************************
	initial begin
		enc_turns      = '0;
		enc_angle      = '0;
		enc_stb        = 1'b0;
		enc_batt_first = 1'b0;
		enc_batt_low   = 1'b0;
	end

	//****************************************
	// One frame: settle, strobe, hold, release
	//****************************************
	task automatic sample(input logic [TURN_W-1:0] t, input logic [ANG_W-1:0] a);
		enc_turns <= t;
		enc_angle <= a;
		repeat (3) @(posedge clk);
		enc_stb <= 1'b1;
		repeat (4) @(posedge clk);
		enc_stb <= 1'b0;
		repeat (3) @(posedge clk);
		// Released word shows garbage, so stale data cannot pass
		enc_turns <= ~t;
		enc_angle <= ~a;
		@(posedge clk);
		#1;
	endtask

	// Battery flags are plain levels
	task automatic set_batt(input logic first, input logic low);
		enc_batt_first <= first;
		enc_batt_low   <= low;
	endtask
endmodule

// ==== verif/tb_aep_tracker.sv ====
// Self-checking bench for the absolute encoder position tracker
module tb_aep_tracker
	import aep_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;

	//****************************************
	// Signals
	//****************************************
	logic              clk;
	logic              srst;
	logic [ADDR_W-1:0] addr;
	logic [DATA_W-1:0] wdata;
	logic              wr;
	logic              rd;
	logic [DATA_W-1:0] rdata;
	logic              irq;
	logic              home_needed;
	logic [DATA_W-1:0] mech_pos;
	logic [DATA_W-1:0] pos_error;
	logic [TURN_W-1:0] enc_turns;
	logic [ANG_W-1:0]  enc_angle;
	logic              enc_stb;
	logic              enc_batt_first;
	logic              enc_batt_low;
	int                errors = 0;
	int                compares = 0;

	// 100 MHz clock
	initial clk = 1'b0;
	always #5 clk = ~clk;

	//****************************************
	// Design and encoder
	//****************************************
	aep_tracker aep_tracker_inst (
		.clk(clk), .srst(srst), .enc_turns(enc_turns), .enc_angle(enc_angle),
		.enc_stb(enc_stb), .enc_batt_first(enc_batt_first),
		.enc_batt_low(enc_batt_low), .addr(addr), .wdata(wdata), .wr(wr),
		.rd(rd), .rdata(rdata), .irq(irq), .home_needed(home_needed),
		.mech_pos(mech_pos), .pos_error(pos_error)
	);
	aep_enc_model aep_enc_model_inst (
		.clk(clk), .enc_turns(enc_turns), .enc_angle(enc_angle),
		.enc_stb(enc_stb), .enc_batt_first(enc_batt_first),
		.enc_batt_low(enc_batt_low)
	);

	//****************************************
	// Compare, bus and closing tasks
	//****************************************
	task automatic chk_word(input logic [DATA_W-1:0] got, exp, input string what);
		compares++;
		if (got !== exp) begin
			errors++;
			$display("wrong value at %0t: %s got %h want %h", $time, what, got, exp);
		end
	endtask

	task automatic chk_bit(input logic got, exp, input string what);
		compares++;
		if (got !== exp) begin
			errors++;
			$display("wrong value at %0t: %s got %b want %b", $time, what, got, exp);
		end
	endtask

	// Idle cycles, then let the edge's updates land
	task automatic idle(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask

	task automatic wreg(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
		@(posedge clk);
		addr  <= a;
		wdata <= d;
		wr    <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
	endtask

	// Read data stands only in the cycle after the strobe
	task automatic rd_chk(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] exp,
		input string what);
		@(posedge clk);
		addr <= a;
		rd   <= 1'b1;
		@(posedge clk);
		rd <= 1'b0;
		#1;
		chk_word(rdata, exp, what);
	endtask

	task automatic do_reset();
		aep_enc_model_inst.set_batt(1'b0, 1'b0);
		@(posedge clk);
		srst <= 1'b1;
		repeat (2) @(posedge clk);
		srst <= 1'b0;
		idle(1);
	endtask

	task automatic tally_and_finish();
		$display("compares %0d errors %0d", compares, errors);
		if (errors == 0 && compares > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask

	//****************************************
	// Scenarios
	//****************************************
	task automatic t_reset();
		chk_bit(irq, 1'b0, "irq");
		chk_bit(home_needed, 1'b1, "home");
		chk_word(mech_pos, '0, "mech");
		chk_word(pos_error, '0, "err");
		rd_chk(A_CTRL, 32'h0, "ctrl");
		rd_chk(A_STATE, 32'h1, "state");
		rd_chk(A_CLEAR, 32'h0, "clear");
		rd_chk(8'h3C, 32'h0, "unmapped");
		$display("test reset done");
	endtask

	// Absolute 24-bit: first battery, homing keeps encoder position
	task automatic t_absolute();
		wreg(A_CTRL, 32'h3);
		aep_enc_model_inst.set_batt(1'b1, 1'b0);
		aep_enc_model_inst.sample(16'h0003, 24'h000100);
		rd_chk(A_TURNS, 32'h3, "turns");
		rd_chk(A_ANGLE, 32'h100, "angle");
		rd_chk(A_ENC_LO, 32'h03000100, "enc lo");
		rd_chk(A_ENC_HI, 32'h0, "enc hi");
		rd_chk(A_STATUS, 32'h2, "status");
		wreg(A_CTRL, 32'h7);
		idle(6);
		rd_chk(A_CTRL, 32'h3, "ctrl");
		rd_chk(A_ENC_LO, 32'h03000100, "enc kept");
		rd_chk(A_OFS_LO, 32'h03000100, "offset");
		chk_word(mech_pos, 32'h0, "mech");
		chk_bit(home_needed, 1'b0, "home");
		aep_enc_model_inst.set_batt(1'b0, 1'b0);
		aep_enc_model_inst.sample(16'h0003, 24'h000200);
		chk_word(mech_pos, 32'h100, "mech");
		wreg(A_TARGET, 32'h300);
		idle(6);
		chk_word(pos_error, 32'h200, "err");
		rd_chk(A_STATUS, 32'hA, "status");
		// Software restores a far offset, mechanical goes negative
		wreg(A_OFS_HI, 32'h1);
		idle(3);
		rd_chk(A_OFS_HI, 32'h1, "ofs hi");
		rd_chk(A_MECH_HI, 32'hFFFFFFFF, "mech hi");
		$display("test absolute done");
	endtask

	// Absolute 17-bit: wrap past 32767 turns, then battery-low interrupt
	task automatic t_overflow();
		do_reset();
		wreg(A_CTRL, 32'h1);
		aep_enc_model_inst.sample(16'h7FFF, 24'hFDFF00);
		rd_chk(A_ANGLE, 32'h1FF00, "mask");
		rd_chk(A_STATUS, 32'h0, "in range");
		aep_enc_model_inst.sample(16'h7FFF, 24'h000100);
		rd_chk(A_TURNS, 32'h8000, "turns");
		rd_chk(A_ENC_HI, 32'h1, "enc hi");
		rd_chk(A_STATUS, 32'h1, "ovf");
		wreg(A_ENABLE, 32'h4);
		aep_enc_model_inst.set_batt(1'b0, 1'b1);
		idle(5);
		aep_enc_model_inst.set_batt(1'b0, 1'b0);
		idle(5);
		chk_bit(irq, 1'b1, "irq low");
		rd_chk(A_STATUS, 32'h5, "latched");
		wreg(A_CLEAR, 32'h4);
		idle(3);
		chk_bit(irq, 1'b0, "irq clr");
		rd_chk(A_STATUS, 32'h1, "cleared");
		wreg(A_ENABLE, 32'h1);
		idle(3);
		chk_bit(irq, 1'b1, "irq ovf");
		wreg(A_ENABLE, 32'h0);
		idle(3);
		chk_bit(irq, 1'b0, "masked");
		$display("test overflow done");
	endtask

	// Incremental: turns dropped, homing zeroes encoder position
	task automatic t_incremental();
		do_reset();
		wreg(A_CTRL, 32'h2);
		aep_enc_model_inst.set_batt(1'b1, 1'b0);
		aep_enc_model_inst.sample(16'h0005, 24'h000100);
		rd_chk(A_TURNS, 32'h0, "turns");
		rd_chk(A_STATUS, 32'h0, "no fail");
		chk_bit(home_needed, 1'b1, "home");
		wreg(A_CTRL, 32'h6);
		idle(6);
		rd_chk(A_ENC_LO, 32'h0, "enc zero");
		rd_chk(A_OFS_LO, 32'h0, "offset");
		aep_enc_model_inst.sample(16'h0005, 24'h000300);
		chk_word(mech_pos, 32'h200, "mech");
		rd_chk(A_ENC_LO, 32'h200, "enc");
		// Backward wrap through zero counts one turn down
		aep_enc_model_inst.sample(16'h0005, 24'hFFFF00);
		rd_chk(A_TURNS, 32'hFFFFFFFF, "turns back");
		chk_word(mech_pos, 32'hFFFFFE00, "mech back");
		chk_bit(home_needed, 1'b0, "home");
		do_reset();
		chk_bit(home_needed, 1'b1, "rehome");
		$display("test incremental done");
	endtask

	//****************************************
	// Main sequence and watchdog
	//****************************************
	initial begin
		srst  = 1'b1;
		addr  = '0;
		wdata = '0;
		wr    = 1'b0;
		rd    = 1'b0;
		repeat (2) @(posedge clk);
		srst <= 1'b0;
		idle(1);
		t_reset();
		t_absolute();
		t_overflow();
		t_incremental();
		tally_and_finish();
	end

	// Tests need well under a thousand cycles
	initial begin
		repeat (20000) @(posedge clk);
		errors++;
		tally_and_finish();
	end
endmodule
